// ---- core/perf_sel_pkg.sv ----
// constants, types and shared decode helpers for the event-select counter
package perf_sel_pkg;

    // ==========================================================
    // event codes
    localparam logic [7:0] EV_L2_FETCH = 8'h28;
    localparam logic [7:0] EV_L2_READ = 8'h29;
    localparam logic [7:0] EV_L2_WRITE = 8'h2a;
    localparam logic [7:0] EV_L2_REQ = 8'h2e;
    localparam logic [7:0] EV_L2_REFUSE = 8'h30;
    localparam logic [7:0] EV_L2_IDLE = 8'h32;
    localparam logic [7:0] EV_PSTATE = 8'h3a;
    localparam logic [7:0] EV_THERMAL = 8'h3b;
    localparam logic [7:0] EV_ACTIVE = 8'h3c;
    localparam logic [7:0] EV_L1_READ = 8'h40;
    localparam logic [7:0] EV_L1_WRITE = 8'h41;
    localparam logic [7:0] EV_L1_LOCK = 8'h42;
    localparam logic [7:0] EV_MEM_REF = 8'h43;
    localparam logic [7:0] EV_MEM_CREF = 8'h44;
    localparam logic [7:0] EV_L1_REPL = 8'h45;
    localparam logic [7:0] EV_M_ALLOC = 8'h46;
    localparam logic [7:0] EV_M_EVICT = 8'h47;
    localparam logic [7:0] EV_PEND_MISS = 8'h48;
    localparam logic [7:0] EV_DTLB_MISS = 8'h49;
    localparam logic [7:0] EV_SW_PREF = 8'h4b;
    localparam logic [7:0] EV_L1_PREF = 8'h4f;

    // ==========================================================
    // fixed unit-mask values
    localparam logic [7:0] UM_NONE = 8'h00;
    localparam logic [7:0] UM_FREQ = 8'h10;
    localparam logic [7:0] UM_THERMAL = 8'hc0;
    localparam logic [7:0] UM_ACTIVE = 8'h01;
    localparam logic [7:0] UM_SERIAL = 8'h02;
    localparam logic [7:0] UM_ALL_REF = 8'h01;
    localparam logic [7:0] UM_CACHE_REF = 8'h02;
    localparam logic [7:0] UM_REPL = 8'h0f;
    localparam logic [7:0] UM_SW_PREF_MAX = 8'h03;

    // ==========================================================
    // unit-mask field positions
    localparam int UM_MESI_LSB = 0; // bit3 M, bit2 E, bit1 S, bit0 I
    localparam int UM_NO_PREF_BIT = 4; // set: drop hardware-prefetch requests
    localparam int UM_NO_DEMAND_BIT = 5; // set: drop demand requests
    localparam int UM_THIS_CORE_BIT = 6;
    localparam int UM_OTHER_CORE_BIT = 7;

    // ==========================================================
    // second-level request kinds
    localparam logic [1:0] L2_KIND_FETCH = 2'h0;
    localparam logic [1:0] L2_KIND_READ = 2'h1;
    localparam logic [1:0] L2_KIND_WRITE = 2'h2;

    // ==========================================================
    // register map (byte offsets) and fields
    localparam logic [3:0] OFF_SELECT = 4'h0;
    localparam logic [3:0] OFF_COUNT = 4'h4;
    localparam logic [3:0] OFF_STATUS = 4'h8;
    localparam int SEL_CODE_LSB = 0;
    localparam int SEL_UMASK_LSB = 8;
    localparam int SEL_EDGE_BIT = 18;
    localparam int SEL_ENABLE_BIT = 22;
    localparam int SEL_CMASK_LSB = 24;
    localparam int STAT_WRAP_BIT = 0;
    localparam int STAT_DEFINED_BIT = 1;
    localparam logic [31:0] SELECT_RESET = 32'h0000_0000;
    localparam logic [31:0] COUNT_RESET = 32'h0000_0000;

    // ==========================================================
    // bus handshake states
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } bus_state_t;

    // any selected line state present in the access
    function automatic logic mesi_hit(input logic [3:0] state, input logic [7:0] umask);
        mesi_hit = |(state & umask[UM_MESI_LSB +: 4]);
    endfunction

    // core filter: 00 is read as this core only
    function automatic logic core_hit(input logic other, input logic [7:0] umask);
        core_hit = other ? umask[UM_OTHER_CORE_BIT]
                         : (umask[UM_THIS_CORE_BIT] | ~umask[UM_OTHER_CORE_BIT]);
    endfunction

endpackage

// ---- core/event_decode.sv ----
// maps event code and unit mask onto one per-cycle increment
module event_decode (
    input wire logic [7:0] code, // selected event code
    input wire logic [7:0] umask, // selected unit mask
    input wire logic l2_valid, // second-level access this cycle
    input wire logic [1:0] l2_kind, // fetch, read or write
    input wire logic [3:0] l2_state, // line state, one-hot M E S I
    input wire logic l2_other_core, // access issued by the other core
    input wire logic l2_hw_prefetch, // access issued by hardware prefetch
    input wire logic l2_refusing, // second level busy and refusing
    input wire logic l2_no_request, // no second-level request present
    input wire logic pstate_any, // performance-state transition pulse
    input wire logic pstate_freq, // frequency transition pulse
    input wire logic thermal_trip, // in thermal trip
    input wire logic bus_tick, // one core cycle per bus cycle
    input wire logic core_halted, // this core halted
    input wire logic other_halted, // other core halted
    input wire logic l1_read, // first-level data read
    input wire logic l1_write, // first-level data write
    input wire logic l1_lock_read, // first-level locked read
    input wire logic l1_cacheable, // access is cacheable
    input wire logic [3:0] l1_state, // line state, one-hot M E S I
    input wire logic l1_replace, // first-level line replaced
    input wire logic l1_m_alloc, // modified line allocated
    input wire logic l1_m_evict, // modified line evicted
    input wire logic [3:0] l1_pending, // outstanding first-level misses
    input wire logic dtlb_miss, // data translation miss
    input wire logic sw_pref_miss, // software prefetch or stream missed all
    input wire logic [1:0] sw_pref_kind, // 0 nta, 1 t1, 2 t2, 3 stream
    input wire logic first_level_prefetch_requests, // first-level prefetch request
    output logic [3:0] inc, // increment for this cycle
    output logic defined // code and mask form a known pair
);

    // ==========================================================
    // qualifiers
    wire l2_q = l2_valid & perf_sel_pkg::mesi_hit(l2_state, umask)
        & perf_sel_pkg::core_hit(l2_other_core, umask);
    wire pf_q = l2_hw_prefetch ? ~umask[perf_sel_pkg::UM_NO_PREF_BIT]
                               : ~umask[perf_sel_pkg::UM_NO_DEMAND_BIT];
    wire l1_q = l1_cacheable & perf_sel_pkg::mesi_hit(l1_state, umask);
    wire um_none = umask == perf_sel_pkg::UM_NONE;

    // ==========================================================
    // per-event selects, each true when the pair is legal
    wire s_fetch = code == perf_sel_pkg::EV_L2_FETCH;
    wire s_read = code == perf_sel_pkg::EV_L2_READ;
    wire s_write = code == perf_sel_pkg::EV_L2_WRITE;
    wire s_req = code == perf_sel_pkg::EV_L2_REQ;
    wire s_refuse = code == perf_sel_pkg::EV_L2_REFUSE;
    wire s_idle = code == perf_sel_pkg::EV_L2_IDLE;
    wire s_ps_any = code == perf_sel_pkg::EV_PSTATE && um_none;
    wire s_ps_freq = code == perf_sel_pkg::EV_PSTATE && umask == perf_sel_pkg::UM_FREQ;
    wire s_thermal = code == perf_sel_pkg::EV_THERMAL && umask == perf_sel_pkg::UM_THERMAL;
    wire s_active = code == perf_sel_pkg::EV_ACTIVE && umask == perf_sel_pkg::UM_ACTIVE;
    wire s_serial = code == perf_sel_pkg::EV_ACTIVE && umask == perf_sel_pkg::UM_SERIAL;
    wire s_l1rd = code == perf_sel_pkg::EV_L1_READ;
    wire s_l1wr = code == perf_sel_pkg::EV_L1_WRITE;
    wire s_lock = code == perf_sel_pkg::EV_L1_LOCK;
    wire s_ref = code == perf_sel_pkg::EV_MEM_REF && umask == perf_sel_pkg::UM_ALL_REF;
    wire s_cref = code == perf_sel_pkg::EV_MEM_CREF && umask == perf_sel_pkg::UM_CACHE_REF;
    wire s_repl = code == perf_sel_pkg::EV_L1_REPL && umask == perf_sel_pkg::UM_REPL;
    wire s_malloc = code == perf_sel_pkg::EV_M_ALLOC && um_none;
    wire s_mevict = code == perf_sel_pkg::EV_M_EVICT && um_none;
    wire s_pend = code == perf_sel_pkg::EV_PEND_MISS && um_none;
    wire s_dtlb = code == perf_sel_pkg::EV_DTLB_MISS && um_none;
    wire s_swpf = code == perf_sel_pkg::EV_SW_PREF && umask <= perf_sel_pkg::UM_SW_PREF_MAX;
    wire s_l1pf = code == perf_sel_pkg::EV_L1_PREF && um_none;

    // ==========================================================
    // single-count sources; only one select can be true at a time
    wire fire =
        (s_fetch & l2_q & l2_kind == perf_sel_pkg::L2_KIND_FETCH) | // R1
        (s_read & l2_q & l2_kind == perf_sel_pkg::L2_KIND_READ) | // R2
        (s_write & l2_q & l2_kind == perf_sel_pkg::L2_KIND_WRITE) | // R2
        (s_req & l2_q & pf_q) | // R3
        (s_refuse & l2_refusing) | // R4
        (s_idle & l2_no_request) | // R5
        (s_ps_any & pstate_any) | // R6
        (s_ps_freq & pstate_freq) | // R6
        (s_thermal & thermal_trip) | // R7
        (s_active & bus_tick & ~core_halted) | // R8
        (s_serial & bus_tick & ~core_halted & other_halted) | // R8
        (s_l1rd & l1_read & l1_q) | // R9
        (s_l1wr & l1_write & l1_q) | // R9
        (s_lock & l1_lock_read & l1_q) | // R10
        (s_ref & (l1_read | l1_write)) | // R11
        (s_cref & (l1_read | l1_write) & l1_cacheable) | // R11
        (s_repl & l1_replace) | // R12
        (s_malloc & l1_m_alloc) | // R13
        (s_mevict & l1_m_evict) | // R13
        (s_dtlb & dtlb_miss) | // R15
        (s_swpf & sw_pref_miss & sw_pref_kind == umask[1:0]) | // R16
        (s_l1pf & first_level_prefetch_requests); // R17, resubmitted requests count again

    // the weighted miss event adds the whole outstanding count
    assign inc = s_pend ? l1_pending : {3'h0, fire}; // R14
    assign defined = s_fetch | s_read | s_write | s_req | s_refuse | s_idle
        | s_ps_any | s_ps_freq | s_thermal | s_active | s_serial | s_l1rd
        | s_l1wr | s_lock | s_ref | s_cref | s_repl | s_malloc | s_mevict
        | s_pend | s_dtlb | s_swpf | s_l1pf; // R19

endmodule

// ---- core/perf_counter.sv ----
// event-select performance counter with an avalon-mm register slave
// Contract
// [R1] 28H counts second-level code fetches, speculative too, by line state and core.
// [R2] 29H counts second-level reads, 2AH writes, by line state and core.
// [R3] 2EH counts all second-level requests, by state, core and prefetch bits.
// [R4] 30H counts each cycle the second level is busy refusing requests.
// [R5] 32H counts each cycle with no second-level request.
// [R6] 3AH counts all state transitions with mask 00H, frequency ones with 10H.
// [R7] 3BH mask C0H counts thermal trip cycles; edge mode counts trips.
// [R8] 3CH mask 01H active bus cycles; 02H only while other core halts.
// [R9] 40H counts cacheable first-level reads, 41H writes, by line state.
// [R10] 42H counts cacheable first-level locked reads, filtered by line state.
// [R11] 43H/01H counts all first-level accesses; 44H/02H cacheable ones only.
// [R12] 45H with mask 0FH counts first-level line replacements.
// [R13] with mask 00H, 46H counts modified allocations, 47H modified evictions.
// [R14] 48H adds outstanding misses per cycle; threshold one counts busy cycles.
// [R15] 49H with mask 00H counts data translation misses.
// [R16] 4BH counts prefetch or streaming misses; mask 00H-03H picks the kind.
// [R17] 4FH counts first-level prefetch requests; resubmits may count twice.
// [R18] line-state mask bits select M, E, S, I; any selected match counts.
// [R19] only defined code and mask pairs advance the counter.
//
// Added by the designer: the Avalon-MM interface to the registers and the placing of the registers.
module perf_counter (
    input wire logic clock, // core clock, 250 mhz
    input wire logic resetn, // asynchronous reset, active low
    input wire logic [3:0] address, // byte address, word aligned
    input wire logic read, // bus read request
    input wire logic write, // bus write request
    input wire logic [31:0] writedata, // bus write data
    input wire logic [3:0] byteenable, // bus byte lanes
    output logic [31:0] readdata, // bus read data
    output logic waitrequest, // bus stall, low for the answer cycle
    input wire logic l2_valid, // second-level access this cycle
    input wire logic [1:0] l2_kind, // fetch, read or write
    input wire logic [3:0] l2_state, // line state, one-hot M E S I
    input wire logic l2_other_core, // access from the other core
    input wire logic l2_hw_prefetch, // access from hardware prefetch
    input wire logic l2_refusing, // second level refusing requests
    input wire logic l2_no_request, // no second-level request
    input wire logic pstate_any, // performance-state transition pulse
    input wire logic pstate_freq, // frequency transition pulse
    input wire logic thermal_trip, // thermal trip level
    input wire logic bus_tick, // bus cycle marker
    input wire logic core_halted, // this core halted
    input wire logic other_halted, // other core halted
    input wire logic l1_read, // first-level data read
    input wire logic l1_write, // first-level data write
    input wire logic l1_lock_read, // first-level locked read
    input wire logic l1_cacheable, // access cacheable
    input wire logic [3:0] l1_state, // line state, one-hot M E S I
    input wire logic l1_replace, // line replaced
    input wire logic l1_m_alloc, // modified line allocated
    input wire logic l1_m_evict, // modified line evicted
    input wire logic [3:0] l1_pending, // outstanding misses
    input wire logic dtlb_miss, // translation miss
    input wire logic sw_pref_miss, // software prefetch or stream miss
    input wire logic [1:0] sw_pref_kind, // prefetch kind
    input wire logic first_level_prefetch_requests, // first-level prefetch request
    output logic [31:0] count_value // live counter value
);

    // ==========================================================
    // register state
    logic [31:0] select_r;
    logic [31:0] select_nxt;
    logic [31:0] count_r;
    logic [31:0] count_nxt;
    logic wrap_r;
    logic wrap_nxt;
    logic prev_cond_r;
    logic [31:0] readdata_r;
    logic [31:0] readdata_nxt;
    logic waitrequest_r;
    perf_sel_pkg::bus_state_t state_r;
    perf_sel_pkg::bus_state_t state_nxt;

    // ==========================================================
    // select fields
    wire [7:0] sel_code = select_r[perf_sel_pkg::SEL_CODE_LSB +: 8];
    wire [7:0] sel_umask = select_r[perf_sel_pkg::SEL_UMASK_LSB +: 8];
    wire [7:0] sel_cmask = select_r[perf_sel_pkg::SEL_CMASK_LSB +: 8];
    wire sel_edge = select_r[perf_sel_pkg::SEL_EDGE_BIT];
    wire sel_enable = select_r[perf_sel_pkg::SEL_ENABLE_BIT];

    // ==========================================================
    // event decode
    logic [3:0] raw_inc;
    logic defined;

    event_decode decode (
        .code(sel_code),
        .umask(sel_umask),
        .l2_valid(l2_valid),
        .l2_kind(l2_kind),
        .l2_state(l2_state),
        .l2_other_core(l2_other_core),
        .l2_hw_prefetch(l2_hw_prefetch),
        .l2_refusing(l2_refusing),
        .l2_no_request(l2_no_request),
        .pstate_any(pstate_any),
        .pstate_freq(pstate_freq),
        .thermal_trip(thermal_trip),
        .bus_tick(bus_tick),
        .core_halted(core_halted),
        .other_halted(other_halted),
        .l1_read(l1_read),
        .l1_write(l1_write),
        .l1_lock_read(l1_lock_read),
        .l1_cacheable(l1_cacheable),
        .l1_state(l1_state),
        .l1_replace(l1_replace),
        .l1_m_alloc(l1_m_alloc),
        .l1_m_evict(l1_m_evict),
        .l1_pending(l1_pending),
        .dtlb_miss(dtlb_miss),
        .sw_pref_miss(sw_pref_miss),
        .sw_pref_kind(sw_pref_kind),
        .first_level_prefetch_requests(first_level_prefetch_requests),
        .inc(raw_inc),
        .defined(defined)
    );

    // ==========================================================
    // threshold and edge shaping of the increment
    // a nonzero threshold turns the weighted count into a yes/no per cycle
    wire thresh_on = sel_cmask != 8'h00;
    wire thresh_met = {4'h0, raw_inc} >= sel_cmask; // R14
    wire cond = thresh_on ? thresh_met : (raw_inc != 4'h0);
    // edge mode counts only the rising edge of the condition
    wire edge_hit = cond & ~prev_cond_r; // R7
    wire [3:0] shaped = sel_edge ? {3'h0, edge_hit}
                      : (thresh_on ? {3'h0, thresh_met} : raw_inc); // R14
    // an undefined pair or a disabled counter adds nothing
    wire [3:0] step = (defined & sel_enable) ? shaped : 4'h0; // R19
    wire [32:0] sum = {1'b0, count_r} + {29'h0, step};

    // ==========================================================
    // bus address decode
    wire hit_select = address == perf_sel_pkg::OFF_SELECT;
    wire hit_count = address == perf_sel_pkg::OFF_COUNT;
    wire hit_status = address == perf_sel_pkg::OFF_STATUS;
    wire in_ack = state_r == perf_sel_pkg::BUS_ACK;
    // writes land only at the edge where the master sees waitrequest low
    wire take_write = write & in_ack;
    wire [31:0] status_word = {30'h0, defined, wrap_r};
    wire [31:0] read_word = hit_select ? select_r
                          : hit_count ? count_r
                          : hit_status ? status_word
                          : 32'h0000_0000;

    // ==========================================================
    // byte-lane merge for the writable registers
    logic [31:0] select_merged;
    logic [31:0] count_merged;
    logic [31:0] wdata_lane;
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane = lane + 1)
        begin : g_lane
            assign wdata_lane[8*lane +: 8] = byteenable[lane] ? writedata[8*lane +: 8] : 8'h00;
            assign select_merged[8*lane +: 8] = byteenable[lane]
                ? writedata[8*lane +: 8] : select_r[8*lane +: 8];
            assign count_merged[8*lane +: 8] = byteenable[lane]
                ? writedata[8*lane +: 8] : count_r[8*lane +: 8];
        end
    endgenerate

    // ==========================================================
    // next-state values
    // a software load of the counter takes priority over counting that cycle
    assign select_nxt = (take_write & hit_select) ? select_merged : select_r;
    assign count_nxt = (take_write & hit_count) ? count_merged : sum[31:0];
    // wrap flag: a new wrap in the clearing cycle keeps the flag set
    wire wrap_clear = take_write & hit_status & wdata_lane[perf_sel_pkg::STAT_WRAP_BIT];
    wire wrap_set = sum[32] & ~(take_write & hit_count);
    assign wrap_nxt = wrap_set | (wrap_r & ~wrap_clear);
    assign readdata_nxt = (state_nxt == perf_sel_pkg::BUS_ACK && read) ? read_word
                        : 32'h0000_0000;

    // ==========================================================
    // bus handshake: one stall cycle, then one answer cycle
    always_comb
    begin
        case (state_r)
            perf_sel_pkg::BUS_IDLE: state_nxt = (read | write) ? perf_sel_pkg::BUS_ACK
                                                               : perf_sel_pkg::BUS_IDLE;
            perf_sel_pkg::BUS_ACK: state_nxt = perf_sel_pkg::BUS_IDLE;
            default: state_nxt = perf_sel_pkg::BUS_IDLE;
        endcase
    end

    // ==========================================================
    // bus registers
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            state_r <= perf_sel_pkg::BUS_IDLE;
            waitrequest_r <= 1'b1;
            readdata_r <= 32'h0000_0000;
        end
        else
        begin
            state_r <= state_nxt;
            waitrequest_r <= state_nxt != perf_sel_pkg::BUS_ACK;
            readdata_r <= readdata_nxt;
        end
    end

    // ==========================================================
    // counter registers
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            select_r <= perf_sel_pkg::SELECT_RESET;
            count_r <= perf_sel_pkg::COUNT_RESET;
            wrap_r <= 1'b0;
            prev_cond_r <= 1'b0;
        end
        else
        begin
            select_r <= select_nxt;
            count_r <= count_nxt; // R1 R2 R3 R4 R5 R9 R18
            wrap_r <= wrap_nxt;
            prev_cond_r <= cond;
        end
    end

    // outputs come straight from flip-flops
    assign readdata = readdata_r;
    assign waitrequest = waitrequest_r;
    assign count_value = count_r;

endmodule

// ---- verification/perf_counter_properties.sv ----
// assertion checker for the event-select counter and its register bus
module perf_counter_checker (
    input wire logic clock, // core clock
    input wire logic resetn, // asynchronous reset, active low
    input wire logic [3:0] address, // bus address
    input wire logic read, // bus read request
    input wire logic write, // bus write request
    input wire logic [31:0] writedata, // bus write data
    input wire logic [3:0] byteenable, // bus byte lanes
    input wire logic [31:0] readdata, // bus read data
    input wire logic waitrequest, // bus stall
    input wire logic [31:0] count_value // live counter value
);
    // ==========================================================
    // bus and counter relations
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);

    // an unanswered request hangs the master
    answer_bound_a: assert property ((read || write) && waitrequest |-> ##[1:2] !waitrequest)
        else $error("request not answered in time");
    answer_single_a: assert property (!waitrequest |=> waitrequest)
        else $error("answer longer than a cycle");
    answer_cause_a: assert property (!waitrequest |-> $past(read || write))
        else $error("answer without a request");
    data_idle_a: assert property (waitrequest |-> readdata == 32'h0)
        else $error("stray read data");
    write_data_a: assert property (!waitrequest && write |-> readdata == 32'h0)
        else $error("read data on a write answer");
    // a four-bit increment adds fifteen at most
    count_step_a: assert property (!(write && !waitrequest)
        |=> count_value - $past(count_value) <= 32'hf)
        else $error("counter jumped too far");
    count_load_a: assert property (write && !waitrequest && address == perf_sel_pkg::OFF_COUNT
        && byteenable == 4'hf |=> count_value == $past(writedata))
        else $error("counter write lost");
    reset_clear_a: assert property ($rose(resetn) |-> count_value == 32'h0 && waitrequest)
        else $error("state not cleared by reset");

    cover property (read && !waitrequest);
    cover property (write && !waitrequest && address == perf_sel_pkg::OFF_COUNT);
    cover property (count_value != $past(count_value));
endmodule

bind perf_counter perf_counter_checker chk (.clock(clock), .resetn(resetn), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .count_value(count_value));

// ---- verification/perf_counter_tb.sv ----
// self-checking testbench for the event-select counter
module perf_counter_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] address = 4'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] stim = 32'h0;
    logic [31:0] readdata;
    logic [31:0] count_value;
    logic waitrequest;
    logic [31:0] seed = 32'h4802;
    int err_total = 0;
    int checked = 0;
    int cyc = 0;
    // code, unit mask, stim bit; two pairs undefined
    logic [23:0] rows [0:30] = '{24'h280f00, 24'h290f00, 24'h2a0f00, 24'h2e0f00, 24'h2e0500,
        24'h300001, 24'h320002, 24'h3a0003, 24'h3a1004, 24'h3bc005, 24'h3b0005, 24'h3c0106,
        24'h400f07, 24'h400807, 24'h410f08, 24'h420f09, 24'h430107, 24'h440208, 24'h450f0a,
        24'h46000b, 24'h47000c, 24'h480000, 24'h480000, 24'h49000d, 24'h4b000e, 24'h4b010e,
        24'h4b020e, 24'h4b030e, 24'h4b040e, 24'h4f000f, 24'h3c0206};

    perf_counter DUT (.clock(clock), .resetn(resetn), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(4'hf), .readdata(readdata),
        .waitrequest(waitrequest), .l2_valid(stim[0]), .l2_kind(stim[17:16]),
        .l2_state(4'h1 << stim[19:18]), .l2_other_core(stim[20]), .l2_hw_prefetch(stim[21]),
        .l2_refusing(stim[1]), .l2_no_request(stim[2]), .pstate_any(stim[3]),
        .pstate_freq(stim[4]), .thermal_trip(stim[5]), .bus_tick(stim[6]),
        .core_halted(stim[22]), .other_halted(stim[23]), .l1_read(stim[7]),
        .l1_write(stim[8]), .l1_lock_read(stim[9]), .l1_cacheable(stim[24]),
        .l1_state(4'h1 << stim[26:25]), .l1_replace(stim[10]), .l1_m_alloc(stim[11]),
        .l1_m_evict(stim[12]), .l1_pending(stim[30:27]), .dtlb_miss(stim[13]),
        .sw_pref_miss(stim[14]), .sw_pref_kind(stim[17:16]), .first_level_prefetch_requests(stim[15]),
        .count_value(count_value));

    // ==========================================================
    // clock, timeout and helpers
    initial
    begin
        forever #2 clock = ~clock;
    end

    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_total++;
            wrap_up();
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic def_pair(input logic [23:0] row);
        return !((row[23:16] == 8'h4b && row[15:8] > 8'h03)
            || (row[23:16] == 8'h3b && row[15:8] != 8'hc0));
    endfunction

    // per-cycle increment; core bits 00 mean this core only
    function automatic logic [3:0] inc_exp(input logic [23:0] row, input logic [31:0] r);
        logic [7:0] c;
        logic [7:0] u;
        logic e;
        logic l2hit;
        c = row[23:16];
        u = row[15:8];
        e = r[row[3:0]];
        l2hit = e && |((4'h1 << r[19:18]) & u[3:0]) && !r[20];
        if (!def_pair(row))
            return 4'h0;
        case (c)
            8'h28, 8'h29, 8'h2a: return {3'h0, l2hit && r[17:16] == c[1:0]};
            8'h2e: return {3'h0, l2hit};
            8'h40, 8'h41, 8'h42: return {3'h0, e && r[24] && |((4'h1 << r[26:25]) & u[3:0])};
            8'h43, 8'h44: return {3'h0, |r[8:7] && (c[0] || r[24])};
            8'h3c: return {3'h0, e && !r[22] && !(u[1] && !r[23])};
            8'h48: return r[30:27];
            8'h4b: return {3'h0, e && r[17:16] == u[1:0]};
            default: return {3'h0, e};
        endcase
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
        checked++;
        if (seen !== want)
        begin
            err_total++;
            $display("unexpected %s expected %h seen %h", what, want, seen);
        end
    endtask

    // a leading idle edge keeps requests out of one time step
    task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        address <= a;
        writedata <= d;
        write <= 1'b1;
        do @(posedge clock); while (waitrequest !== 1'b0);
        write <= 1'b0;
    endtask

    task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clock);
        address <= a;
        read <= 1'b1;
        do @(posedge clock); while (waitrequest !== 1'b0);
        d = readdata;
        read <= 1'b0;
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ==========================================================
    // main sequence: index bit0 sets threshold 1, bit3 edge mode
    initial
    begin
        logic [31:0] d;
        logic [31:0] sel;
        logic [31:0] r;
        logic [31:0] want;
        logic p;
        repeat (8) @(posedge clock);
        resetn <= 1'b1;
        bus_rd(4'hc, d);
        check("unmapped", d, 32'h0);
        foreach (rows[i])
        begin
            sel = {7'h00, i[0], 5'h08, i[3], 2'h0, rows[i][15:8], rows[i][23:16]};
            bus_wr(perf_sel_pkg::OFF_SELECT, sel);
            bus_wr(perf_sel_pkg::OFF_COUNT, 32'h0);
            want = 32'h0;
            p = 1'b0;
            repeat (40)
            begin
                @(posedge clock);
                r = rnd();
                d = {28'h0, inc_exp(rows[i], r)};
                want += i[3] | i[0] ? {31'h0, d != 0 && !(i[3] && p)} : d;
                p = d != 0;
                stim <= r;
            end
            @(posedge clock);
            stim <= 32'h0;
            bus_rd(perf_sel_pkg::OFF_COUNT, d);
            check("count", d, want);
            bus_rd(perf_sel_pkg::OFF_SELECT, d);
            check("select", d, sel);
            bus_rd(perf_sel_pkg::OFF_STATUS, d);
            check("status", d, {30'h0, def_pair(rows[i]), 1'b0});
        end
        wrap_up();
    end
endmodule
